/* File: logic/rbh_host_port.sv */
// Byte-wide host access port: gating, data bus steering and open-drain outputs.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - Write strobe rising edge stores bus data.
// - Select low required; else bus ignored.
// - Supply good: reads and writes work.
// - Supply low: all accesses blocked.
// - Reset output asserted: accesses refused.
// - One eight-bit word per access.
// - Control B bit selects crystal load.
// - SRAM enable sourced from its input.
// - Reset output open-drain, low only.
// - Interrupt output open-drain, low only.
// - Power-on request open-drain, low only.
// - Five-bit address picks one of 17.
// - Supply fail forces SRAM enable high.
module rbh_host_port
    import rbh_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Host bus pins
    input  wire logic              dev_sel_n,
    input  wire logic              write_n,
    input  wire logic [ADDR_W-1:0] register_address,
    input  wire logic [DATA_W-1:0] data_bus_in,
    output logic      [DATA_W-1:0] data_bus_out,
    output logic                   data_bus_oe,
    // Supply and internal event levels
    input  wire logic              supply_ok,
    input  wire logic              reset_req,
    input  wire logic              irq_req,
    input  wire logic              power_req,
    // External SRAM enable
    input  wire logic              sram_enable_in_n,
    output logic                   sram_enable_out_n,
    // Open-drain outputs
    output logic                   reset_out,
    output logic                   reset_oe,
    output logic                   irq_out,
    output logic                   irq_oe,
    output logic                   power_on_request_n,
    output logic                   power_on_request_oe,
    // Oscillator load select
    output logic                   xtal_load_12p5
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage read only by the second.
    rbh_bus_t bus_s1_ff, bus_s2_ff, nxt_bus_s1, nxt_bus_s2;
    logic     sup_s1_ff, sup_s2_ff, sce_s1_ff, sce_s2_ff;
    logic     rst_s1_ff, rst_s2_ff, irq_s1_ff, irq_s2_ff, pwr_s1_ff, pwr_s2_ff;
    logic     wr_d_ff, nxt_wr_d;

    always_comb begin
        nxt_bus_s1 = '{sel_n: dev_sel_n, wr_n: write_n, addr: register_address, wdata: data_bus_in};
        nxt_bus_s2 = bus_s1_ff;
        nxt_wr_d   = bus_s2_ff.wr_n;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_s1_ff <= '{sel_n: 1'b1, wr_n: 1'b1, addr: '0, wdata: REG_RESET};
            bus_s2_ff <= '{sel_n: 1'b1, wr_n: 1'b1, addr: '0, wdata: REG_RESET};
            wr_d_ff   <= 1'b1;
            {sup_s1_ff, sup_s2_ff, sce_s1_ff, sce_s2_ff} <= 4'hF;
            {rst_s1_ff, rst_s2_ff, irq_s1_ff, irq_s2_ff, pwr_s1_ff, pwr_s2_ff} <= 6'h00;
        end else begin
            bus_s1_ff <= nxt_bus_s1;
            bus_s2_ff <= nxt_bus_s2;
            wr_d_ff   <= nxt_wr_d;
            {sup_s1_ff, sup_s2_ff} <= {supply_ok, sup_s1_ff};
            {sce_s1_ff, sce_s2_ff} <= {sram_enable_in_n, sce_s1_ff};
            {rst_s1_ff, rst_s2_ff} <= {reset_req, rst_s1_ff};
            {irq_s1_ff, irq_s2_ff} <= {irq_req, irq_s1_ff};
            {pwr_s1_ff, pwr_s2_ff} <= {power_req, pwr_s1_ff};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access gating. The write lands once, on the rising strobe edge, so that
    // data settling during a long low strobe cannot leave a partial value.
    logic access_ok, wr_en, rd_act;
    always_comb begin
        access_ok = sup_s2_ff && !rst_s2_ff && !bus_s2_ff.sel_n;
        wr_en     = access_ok && bus_s2_ff.wr_n && !wr_d_ff;
        rd_act    = access_ok && bus_s2_ff.wr_n;
    end

    logic [DATA_W-1:0] rdata, ctrl_b;
    rbh_regmem u_mem (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_en),
        .addr    (bus_s2_ff.addr),
        .wdata   (bus_s2_ff.wdata),
        .rdata   (rdata),
        .ctrl_b  (ctrl_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output registers.
    logic oe_ff, nxt_oe, ceo_ff, nxt_ceo;
    always_comb begin
        nxt_oe  = rd_act;
        nxt_ceo = sup_s2_ff ? sce_s2_ff : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_ff  <= 1'b0;
            ceo_ff <= 1'b1;
        end else begin
            oe_ff  <= nxt_oe;
            ceo_ff <= nxt_ceo;
        end
    end

    assign data_bus_out        = rdata;
    assign data_bus_oe         = oe_ff;
    assign sram_enable_out_n   = ceo_ff;
    assign xtal_load_12p5      = ctrl_b[XTAL_SEL_BIT];
    assign reset_out           = 1'b0;
    assign reset_oe            = rst_s2_ff;
    assign irq_out             = 1'b0;
    assign irq_oe              = irq_s2_ff;
    assign power_on_request_n  = 1'b0;
    assign power_on_request_oe = pwr_s2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    AST_NO_DRIVE_SUPPLY_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        !sup_s2_ff |=> !data_bus_oe) else $error("Bus driven with supply low");
    AST_NO_DRIVE_IN_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        rst_s2_ff |=> !data_bus_oe) else $error("Bus driven during reset output");
    AST_NO_DRIVE_DESELECT: assert property (@(posedge clk) disable iff (sys_rst)
        bus_s2_ff.sel_n |=> !data_bus_oe) else $error("Bus driven while deselected");
    AST_NO_DRIVE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        !bus_s2_ff.wr_n |=> !data_bus_oe) else $error("Bus driven during write");
    AST_READ_DRIVES: assert property (@(posedge clk) disable iff (sys_rst)
        (sup_s2_ff && !rst_s2_ff && !bus_s2_ff.sel_n && bus_s2_ff.wr_n) |=> data_bus_oe)
        else $error("Read not driven");
    AST_CEO_FAIL_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        !sup_s2_ff |=> sram_enable_out_n) else $error("SRAM enable not forced high");
    AST_CEO_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
        sup_s2_ff |=> sram_enable_out_n == $past(sce_s2_ff)) else $error("SRAM enable not following");
    AST_OD_LOW_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        !reset_out && !irq_out && !power_on_request_n) else $error("Open drain driven high");
    AST_IRQ_PULL: assert property (@(posedge clk) disable iff (sys_rst)
        irq_oe == irq_s2_ff) else $error("Interrupt pull mismatch");
endmodule : rbh_host_port
`default_nettype wire

/* File: logic/rbh_regmem.sv */
// Small register memory holding the addressable locations, registered read.
`default_nettype none
module rbh_regmem
    import rbh_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Access
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata,
    output logic      [DATA_W-1:0] ctrl_b
);
    logic [DATA_W-1:0] mem_ff [REG_COUNT];
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = REG_RESET;
        if (32'(addr) < REG_COUNT) begin
            nxt_rdata = mem_ff[addr];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= REG_RESET;
            for (int i = 0; i < int'(REG_COUNT); i++) begin
                mem_ff[i] <= REG_RESET;
            end
        end else begin
            rdata_ff <= nxt_rdata;
            if (wr_en && 32'(addr) < REG_COUNT) begin
                mem_ff[addr] <= wdata;
            end
        end
    end

    assign rdata  = rdata_ff;
    assign ctrl_b = mem_ff[CTRL_B_ADDR];
endmodule : rbh_regmem
`default_nettype wire

/* File: shared/rbh_pkg.sv */
// Shared constants and carrier types of the byte-wide clock host port.
`default_nettype none
package rbh_pkg;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned REG_COUNT   = 17;
    localparam logic [4:0]  CTRL_B_ADDR = 5'h0F;
    localparam int unsigned XTAL_SEL_BIT = 0;
    localparam logic [7:0]  REG_RESET   = 8'h00;

    typedef struct packed {
        logic       sel_n;
        logic       wr_n;
        logic [4:0] addr;
        logic [7:0] wdata;
    } rbh_bus_t;

    typedef struct packed {
        logic       pull_low;
        logic       oe;
    } rbh_od_t;
endpackage : rbh_pkg
`default_nettype wire

/* File: tb/rbh_bus_model.sv */
// Partner model that resolves the shared data bus between host and port.
`default_nettype none
module rbh_bus_model
    import rbh_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Drivers
    input  wire logic              dut_oe,
    input  wire logic [DATA_W-1:0] dut_data,
    input  wire logic              host_oe,
    input  wire logic [DATA_W-1:0] host_data,
    // Resolved bus
    output logic      [DATA_W-1:0] data_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] last_ff = 8'h00;
    // A released bus toggles every cycle so that a stale value never passes for a read.
    assign data_bus = dut_oe ? dut_data : (host_oe ? host_data : ~last_ff);
    always_ff @(posedge clk) begin
        last_ff <= data_bus;
    end
endmodule : rbh_bus_model
`default_nettype wire

/* File: tb/rtc_byte_wide_host_port_tb.sv */
// Self-checking testbench of the byte-wide clock host port.
`default_nettype none
module rtc_byte_wide_host_port_tb;
    import rbh_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, sys_rst = 1'b1, sel_n = 1'b1, wr_n = 1'b1, sup = 1'b1, hoe = 1'b0;
    logic       rreq = 1'b0, ireq = 1'b0, preq = 1'b0, sen = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] hdata = 8'h00, bus, dout;
    logic       doe, seo, r_o, r_oe, i_o, i_oe, p_o, p_oe, xtal;
    int         fail_count = 0, check_count = 0;
    always #10 clk = ~clk;
    rbh_host_port u_dut (.clk(clk), .sys_rst(sys_rst), .dev_sel_n(sel_n), .write_n(wr_n),
        .register_address(addr), .data_bus_in(bus), .data_bus_out(dout), .data_bus_oe(doe),
        .supply_ok(sup), .reset_req(rreq), .irq_req(ireq), .power_req(preq), .sram_enable_in_n(sen),
        .sram_enable_out_n(seo), .reset_out(r_o), .reset_oe(r_oe), .irq_out(i_o), .irq_oe(i_oe),
        .power_on_request_n(p_o), .power_on_request_oe(p_oe), .xtal_load_12p5(xtal));
    rbh_bus_model u_bus (.clk(clk), .dut_oe(doe), .dut_data(dout), .host_oe(hoe),
        .host_data(hdata), .data_bus(bus));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // The host keeps data and select across the strobe's rising edge for the sync delay.
    task automatic wr(input logic s, input logic [4:0] a, input logic [7:0] d);
        sel_n = s;
        addr = a;
        hdata = d;
        hoe = 1'b1;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(3);
        sel_n = 1'b1;
        hoe = 1'b0;
        cyc(3);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic drive);
        int i;
        sel_n = 1'b0;
        addr = a;
        for (i = 0; i < 8 && doe !== 1'b1; i++)
            cyc(1);
        chk(doe, drive);
        if (doe !== drive)
            conclude();
        if (drive)
            chk(bus, exp);
        sel_n = 1'b1;
        cyc(4);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_access;
        wr(1'b0, 5'h05, 8'hA5);
        rd(5'h05, 8'hA5, 1'b1);
        wr(1'b1, 5'h05, 8'h3C);
        rd(5'h05, 8'hA5, 1'b1);
        wr(1'b0, 5'h11, 8'h77);
        rd(5'h11, 8'h00, 1'b1);
    endtask : t_access
    task automatic t_supply;
        wr(1'b0, CTRL_B_ADDR, 8'h01);
        chk(xtal, 1'b1);
        sen = 1'b0;
        cyc(3);
        chk(seo, 1'b0);
        sup = 1'b0;
        cyc(3);
        chk(seo, 1'b1);
        wr(1'b0, 5'h05, 8'h5A);
        rd(5'h05, 8'h00, 1'b0);
        sup = 1'b1;
        rd(5'h05, 8'hA5, 1'b1);
    endtask : t_supply
    task automatic t_reset_out;
        rreq = 1'b1;
        ireq = 1'b1;
        preq = 1'b1;
        cyc(3);
        chk({r_o, i_o, p_o, r_oe, i_oe, p_oe}, 8'h07);
        wr(1'b0, 5'h05, 8'h5A);
        rd(5'h05, 8'h00, 1'b0);
        rreq = 1'b0;
        ireq = 1'b0;
        preq = 1'b0;
        cyc(3);
        chk({r_oe, i_oe, p_oe}, 8'h00);
        rd(5'h05, 8'hA5, 1'b1);
    endtask : t_reset_out
    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(2);
        chk({doe, seo, r_oe, i_oe, p_oe, xtal}, 8'h10);
        t_access();
        t_supply();
        t_reset_out();
        conclude();
    end
endmodule : rtc_byte_wide_host_port_tb
`default_nettype wire
